// *** rtl/oc_pkg.sv ***
// Package: register layout, modes and carriers for the output compare channel
package oc_pkg;
  localparam int          DATA_W        = 16;
  localparam logic [1:0]  ADDR_CONTROL  = 2'h0;
  localparam logic [1:0]  ADDR_PRIMARY  = 2'h1;
  localparam logic [1:0]  ADDR_SECOND   = 2'h2;
  localparam logic [1:0]  ADDR_IRQ      = 2'h3;
  localparam int          BIT_IDLE_HALT = 13;
  localparam int          BIT_FAULT     = 4;
  localparam int          BIT_TBSEL     = 3;
  localparam int          MODE_LSB      = 0;
  localparam int          MODE_MSB      = 2;
  localparam logic [15:0] CONTROL_MASK  = 16'h200F;
  localparam logic [15:0] RESET_VALUE   = 16'h0000;
  localparam int          IRQ_MATCH     = 0;
  localparam int          IRQ_FAULT     = 1;
  localparam int          IRQ_W         = 2;

  typedef enum logic [2:0] {
    MODE_OFF     = 3'b000,
    MODE_SET_HI  = 3'b001,
    MODE_SET_LO  = 3'b010,
    MODE_TOGGLE  = 3'b011,
    MODE_SINGLE  = 3'b100,
    MODE_CONT    = 3'b101,
    MODE_PWM     = 3'b110,
    MODE_PWM_FLT = 3'b111
  } mode_type;

  typedef struct packed {
    logic [1:0]        addr;
    logic [15:0]       wdata;
    logic              wr;
    logic              rd;
  } bus_req_type;

  typedef struct packed {
    logic [15:0]       firstTimeBase;
    logic [15:0]       secondTimeBase;
  } time_base_type;
endpackage

// *** rtl/output_compare_channel.sv ***
// Output compare channel: timer compare, pin drive, status and interrupts
// Notes on behaviour
// [R1] Timer select bit picks second or first base
// [R2] Compare against primary, or primary and secondary
// [R3] Compare matches may raise an interrupt request
// [R4] Mode 000 disables, port logic owns pin
// [R5] Mode 001 starts low, match drives high
// [R6] Mode 010 starts high, match drives low
// [R7] Mode 011 keeps level, match toggles pin
// [R8] Mode 100 single pulse, interrupt on fall
// [R9] Mode 101 repeating pulses, interrupt on falls
// [R10] Mode 110 PWM, no fault, no interrupt
// [R11] Mode 111 PWM, fault fall raises interrupt
// [R12] Fault flag set by fault, hardware clears
// [R13] Idle halt bit stops channel in idle; a mode 111 fault still sets the flag, forces the pin low and interrupts
// [R14] Software stops timer before control writes
// [R15] Primary match sets, secondary match clears
// [R16] Unimplemented control bits read as zero
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module output_compare_channel (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire oc_pkg::bus_req_type   busReq,
  output logic [15:0]                rdata,
  input  wire oc_pkg::time_base_type timeBase,
  input  wire logic                  cpuIdle,
  input  wire logic                  faultInputA,
  output logic                       compareOutputPin,
  output logic                       pinOwned,
  output logic                       irq
);
  import oc_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0]      control;
  logic [15:0]      primaryCompareValue;
  logic [15:0]      secondaryCompareValue;
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqMask;
  logic             pinLevel;
  logic             pulseDone;
  logic             faultSync1;
  logic             faultSync2;
  logic             faultPrev;
  logic             faultFlag;
  logic [15:0]      next_control;
  logic [15:0]      next_primary;
  logic [15:0]      next_secondary;
  logic [IRQ_W-1:0] next_irqStatus;
  logic [IRQ_W-1:0] next_irqMask;
  logic             next_pinLevel;
  logic             next_pulseDone;
  logic             next_faultFlag;
  logic [15:0]      next_rdata;

  mode_type    mode;
  logic [15:0] timerValue;
  logic        running;
  logic        matchPrimary;
  logic        matchSecondary;
  logic        faultFall;
  logic        writeControl;
  logic        matchEvent;
  logic        faultEvent;
  logic        pinFall;
  logic        pinRise;

  assign mode = mode_type'(control[MODE_MSB:MODE_LSB]);
  assign timerValue = control[BIT_TBSEL] ? timeBase.secondTimeBase
                                         : timeBase.firstTimeBase; // R1
  assign running = !(control[BIT_IDLE_HALT] && cpuIdle); // R13
  assign matchPrimary = running && (timerValue == primaryCompareValue); // R2
  assign matchSecondary = running
                          && (timerValue == secondaryCompareValue); // R2
  assign faultFall = faultPrev && !faultSync2;
  assign writeControl = busReq.wr && (busReq.addr == ADDR_CONTROL);
  assign pinFall = pinLevel && !next_pinLevel;
  assign pinRise = !pinLevel && next_pinLevel;

  // ****************************************
  // Pin and sequence
  // ****************************************
  always_comb begin
    next_pinLevel = pinLevel;
    next_pulseDone = pulseDone;
    next_faultFlag = faultFlag;
    if (writeControl) begin
      // Initial level for the newly written mode
      next_pulseDone = 1'b0;
      // A fault in the same cycle as the write still sets the flag while the old mode is 111
      next_faultFlag = (mode == MODE_PWM_FLT) && faultFall; // R12
      case (mode_type'(busReq.wdata[MODE_MSB:MODE_LSB]))
        MODE_SET_HI:  next_pinLevel = 1'b0; // R5
        MODE_SET_LO:  next_pinLevel = 1'b1; // R6
        MODE_TOGGLE:  next_pinLevel = pinLevel; // R7
        MODE_SINGLE:  next_pinLevel = 1'b0; // R8
        MODE_CONT:    next_pinLevel = 1'b0; // R9
        MODE_PWM,
        MODE_PWM_FLT: next_pinLevel = (primaryCompareValue != 16'h0000); // R10
        default:      next_pinLevel = 1'b0; // R4
      endcase
    end else begin
      case (mode)
        MODE_SET_HI: begin
          if (matchPrimary) begin
            next_pinLevel = 1'b1; // R5
          end
        end
        MODE_SET_LO: begin
          if (matchPrimary) begin
            next_pinLevel = 1'b0; // R6
          end
        end
        MODE_TOGGLE: begin
          if (matchPrimary) begin
            next_pinLevel = !pinLevel; // R7
          end
        end
        MODE_SINGLE: begin
          if (!pulseDone && matchPrimary) begin
            next_pinLevel = 1'b1; // R15
          end else if (pinLevel && matchSecondary) begin
            next_pinLevel = 1'b0; // R15
            next_pulseDone = 1'b1; // R8
          end
        end
        MODE_CONT: begin
          if (matchPrimary) begin
            next_pinLevel = 1'b1; // R15
          end else if (matchSecondary) begin
            next_pinLevel = 1'b0; // R9
          end
        end
        MODE_PWM,
        MODE_PWM_FLT: begin
          if (mode == MODE_PWM_FLT && faultFall) begin
            next_faultFlag = 1'b1; // R12
          end
          if (faultFlag || next_faultFlag) begin
            next_pinLevel = 1'b0; // R11
          end else if (running && timerValue == 16'h0000) begin
            next_pinLevel = (primaryCompareValue != 16'h0000); // R10
          end else if (matchPrimary) begin
            next_pinLevel = 1'b0; // R10
          end
        end
        default: next_pinLevel = pinLevel; // R4
      endcase
    end
  end

  // ****************************************
  // Interrupt events
  // ****************************************
  always_comb begin
    matchEvent = 1'b0;
    faultEvent = 1'b0;
    if (!writeControl) begin
      case (mode)
        MODE_SET_HI:  matchEvent = matchPrimary; // R3
        MODE_SET_LO:  matchEvent = matchPrimary; // R3
        MODE_TOGGLE:  matchEvent = matchPrimary; // R3
        MODE_SINGLE:  matchEvent = pinFall; // R8
        MODE_CONT:    matchEvent = pinFall; // R9
        MODE_PWM_FLT: faultEvent = faultFall; // R11
        default:      matchEvent = 1'b0; // R10
      endcase
    end
    faultEvent = (mode == MODE_PWM_FLT) && faultFall; // R11
  end

  // ****************************************
  // Register file
  // ****************************************
  always_comb begin
    next_control = control;
    next_primary = primaryCompareValue;
    next_secondary = secondaryCompareValue;
    next_irqMask = irqMask;
    next_irqStatus = irqStatus;
    next_rdata = 16'h0000;
    if (busReq.wr) begin
      case (busReq.addr)
        ADDR_CONTROL: next_control = busReq.wdata & CONTROL_MASK; // R16
        ADDR_PRIMARY: next_primary = busReq.wdata;
        ADDR_SECOND:  next_secondary = busReq.wdata;
        default: begin
          next_irqMask = busReq.wdata[IRQ_W+7:8];
          next_irqStatus = irqStatus & ~busReq.wdata[IRQ_W-1:0];
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    next_irqStatus[IRQ_MATCH] = next_irqStatus[IRQ_MATCH] | matchEvent;
    next_irqStatus[IRQ_FAULT] = next_irqStatus[IRQ_FAULT] | faultEvent;
    if (busReq.rd) begin
      case (busReq.addr)
        ADDR_CONTROL: begin
          next_rdata = control & CONTROL_MASK; // R16
          next_rdata[BIT_FAULT] = faultFlag; // R12
        end
        ADDR_PRIMARY: next_rdata = primaryCompareValue;
        ADDR_SECOND:  next_rdata = secondaryCompareValue;
        default: next_rdata = {6'h00, irqMask, 6'h00, irqStatus};
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      control <= RESET_VALUE;
      primaryCompareValue <= RESET_VALUE;
      secondaryCompareValue <= RESET_VALUE;
      irqStatus <= '0;
      irqMask <= '0;
      rdata <= RESET_VALUE;
      pinLevel <= 1'b0;
      pulseDone <= 1'b0;
      faultFlag <= 1'b0;
      faultSync1 <= 1'b1;
      faultSync2 <= 1'b1;
      faultPrev <= 1'b1;
    end else begin
      control <= next_control;
      primaryCompareValue <= next_primary;
      secondaryCompareValue <= next_secondary;
      irqStatus <= next_irqStatus;
      irqMask <= next_irqMask;
      rdata <= next_rdata;
      pinLevel <= next_pinLevel;
      pulseDone <= next_pulseDone;
      faultFlag <= next_faultFlag;
      faultSync1 <= faultInputA;
      faultSync2 <= faultSync1;
      faultPrev <= faultSync2;
    end
  end

  assign compareOutputPin = pinLevel;
  assign pinOwned = (mode != MODE_OFF); // R4
  assign irq = |(irqStatus & irqMask);

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_primaryHit;
    !writeControl && matchPrimary;
  endsequence

  property p_setHigh;
    @(posedge mclk) disable iff (rst)
      ((mode == MODE_SET_HI) and s_primaryHit) |=> pinLevel;
  endproperty
  a_setHigh: assert property (p_setHigh) else $error("no rise"); // R5

  property p_setLow;
    @(posedge mclk) disable iff (rst)
      ((mode == MODE_SET_LO) and s_primaryHit) |=> !pinLevel;
  endproperty
  a_setLow: assert property (p_setLow) else $error("no fall"); // R6

  property p_toggle;
    @(posedge mclk) disable iff (rst)
      ((mode == MODE_TOGGLE) and s_primaryHit)
      |=> pinLevel != $past(pinLevel);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle"); // R7

  property p_disabled;
    @(posedge mclk) disable iff (rst)
      (mode == MODE_OFF) |-> !pinOwned && !matchEvent;
  endproperty
  a_disabled: assert property (p_disabled) else $error("off drives"); // R4

  property p_singleIrq;
    @(posedge mclk) disable iff (rst)
      (mode == MODE_SINGLE) && !writeControl && pinFall
      |=> irqStatus[IRQ_MATCH];
  endproperty
  a_singleIrq: assert property (p_singleIrq) else $error("no irq"); // R8

  property p_contPulse;
    @(posedge mclk) disable iff (rst)
      (mode == MODE_CONT) && !writeControl && matchPrimary
      |=> pinLevel;
  endproperty
  a_contPulse: assert property (p_contPulse) else $error("no set"); // R15

  property p_pwmNoIrq;
    @(posedge mclk) disable iff (rst)
      (mode == MODE_PWM) && !busReq.wr
      |=> irqStatus == $past(irqStatus);
  endproperty
  a_pwmNoIrq: assert property (p_pwmNoIrq) else $error("pwm irq"); // R10

  property p_faultFlag;
    @(posedge mclk) disable iff (rst)
      (mode == MODE_PWM_FLT) && !writeControl && faultFall
      |=> faultFlag && !pinLevel && irqStatus[IRQ_FAULT];
  endproperty
  a_faultFlag: assert property (p_faultFlag) else $error("fault"); // R11

  property p_halt;
    @(posedge mclk) disable iff (rst)
      control[BIT_IDLE_HALT] && cpuIdle && !busReq.wr
      && mode != MODE_PWM_FLT |=> $stable(pinLevel);
  endproperty
  a_halt: assert property (p_halt) else $error("ran in idle"); // R13

  property p_pwmSet;
    @(posedge mclk) disable iff (rst)
      (mode == MODE_PWM) && !writeControl && running
      && (timerValue == 16'h0000) && (primaryCompareValue != 16'h0000)
      |=> pinLevel;
  endproperty
  a_pwmSet: assert property (p_pwmSet) else $error("pwm no set"); // R10

  property p_pwmClear;
    @(posedge mclk) disable iff (rst)
      (mode == MODE_PWM) && !writeControl && matchPrimary
      |=> !pinLevel;
  endproperty
  a_pwmClear: assert property (p_pwmClear) else $error("pwm no clear"); // R10

  property p_contClear;
    @(posedge mclk) disable iff (rst)
      (mode == MODE_CONT) && !writeControl && matchSecondary
      && !matchPrimary |=> !pinLevel;
  endproperty
  a_contClear: assert property (p_contClear) else $error("no clear"); // R15

  property p_singleOnce;
    @(posedge mclk) disable iff (rst)
      (mode == MODE_SINGLE) && !writeControl && pulseDone
      |=> !pinLevel;
  endproperty
  a_singleOnce: assert property (p_singleOnce) else $error("repeat"); // R8

  property p_faultSticky;
    @(posedge mclk) disable iff (rst)
      faultFlag && !writeControl
      |=> faultFlag;
  endproperty
  a_faultSticky: assert property (p_faultSticky) else $error("flag"); // R12

  property p_initHigh;
    @(posedge mclk) disable iff (rst)
      writeControl && (busReq.wdata[MODE_MSB:MODE_LSB] == MODE_SET_LO)
      |=> pinLevel;
  endproperty
  a_initHigh: assert property (p_initHigh) else $error("no init"); // R6
endmodule // output_compare_channel

// *** tb/testbench.sv ***
// Testbench: drives the output compare channel and judges its outputs
`timescale 1ns/1ps
module testbench;
  import oc_pkg::*;
  localparam logic [15:0] IDLE = 16'hFFFE;
  logic          mclk;
  logic          rst;
  bus_req_type   busReq;
  logic [15:0]   rdata;
  time_base_type timeBase;
  logic          cpuIdle;
  logic          faultInputA;
  logic          compareOutputPin;
  logic          pinOwned;
  logic          irq;
  int            miscompares;
  int            compares;
  int            cycles;

  output_compare_channel i_dut (
    .mclk(mclk), .rst(rst), .busReq(busReq), .rdata(rdata),
    .timeBase(timeBase), .cpuIdle(cpuIdle), .faultInputA(faultInputA),
    .compareOutputPin(compareOutputPin), .pinOwned(pinOwned), .irq(irq)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(logic [1:0] a, logic [15:0] d);
    @(posedge mclk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    busReq <= '{a, d, 1'b0, 1'b0};
    #1;
  endtask

  task automatic rd(logic [1:0] a, logic [15:0] exp, string name);
    @(posedge mclk);
    busReq <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge mclk);
    busReq <= '{a, 16'h0000, 1'b0, 1'b0};
    #1;
    check(name, rdata, exp);
  endtask

  // Timer values stand one cycle, then move off any compare value
  task automatic hit(logic [15:0] a, logic [15:0] b);
    @(posedge mclk);
    timeBase <= '{a, b};
    @(posedge mclk);
    timeBase <= '{IDLE, IDLE};
    #1;
  endtask

  // Timers sit off match while control is written
  task automatic setup(logic [15:0] ctl, logic [15:0] pri);
    wr(ADDR_PRIMARY, pri);
    wr(ADDR_SECOND, 16'h0020);
    wr(ADDR_IRQ, 16'h0303);
    wr(ADDR_CONTROL, ctl);
  endtask

  task automatic pulse_modes();
    setup(16'h0005, 16'h0010);
    check("cont init", compareOutputPin, 16'h0);
    hit(16'h0010, IDLE);
    check("cont set", compareOutputPin, 16'h1);
    check("cont irq rise", irq, 16'h0);
    hit(16'h0020, IDLE);
    check("cont clear", compareOutputPin, 16'h0);
    check("cont irq fall", irq, 16'h1);
    hit(16'h0010, IDLE);
    check("cont repeat", compareOutputPin, 16'h1);
    setup(16'h0004, 16'h0010);
    hit(16'h0010, IDLE);
    hit(16'h0020, IDLE);
    check("single irq", irq, 16'h1);
    hit(16'h0010, IDLE);
    check("single once", compareOutputPin, 16'h0);
    $display("test pulse modes done");
  endtask

  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    busReq = '{2'h0, 16'h0000, 1'b0, 1'b0};
    timeBase = '{IDLE, IDLE};
    cpuIdle = 1'b0;
    faultInputA = 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(ADDR_CONTROL, RESET_VALUE, "control reset");
    check("owned reset", pinOwned, 16'h0);
    check("irq reset", irq, 16'h0);
    $display("test reset done");
    setup(16'hFFE9, 16'h0010);
    rd(ADDR_CONTROL, 16'h2009, "control mask");
    check("owned", pinOwned, 16'h1);
    check("hi init", compareOutputPin, 16'h0);
    hit(16'h0010, 16'h0011);
    check("other base", compareOutputPin, 16'h0);
    hit(16'h0011, 16'h0010);
    check("hi match", compareOutputPin, 16'h1);
    check("match irq", irq, 16'h1);
    rd(ADDR_IRQ, 16'h0301, "irq status");
    setup(16'h0002, 16'h0010);
    check("lo init", compareOutputPin, 16'h1);
    hit(16'h0010, IDLE);
    check("lo match", compareOutputPin, 16'h0);
    setup(16'h0003, 16'h0010);
    check("tog keep", compareOutputPin, 16'h0);
    hit(16'h0010, IDLE);
    check("tog one", compareOutputPin, 16'h1);
    hit(16'h0010, IDLE);
    check("tog two", compareOutputPin, 16'h0);
    $display("test static modes done");
    pulse_modes();
    setup(16'h2001, 16'h0010);
    @(posedge mclk);
    cpuIdle <= 1'b1;
    hit(16'h0010, IDLE);
    check("idle halt", compareOutputPin, 16'h0);
    setup(16'h0001, 16'h0010);
    hit(16'h0010, IDLE);
    check("idle run", compareOutputPin, 16'h1);
    @(posedge mclk);
    cpuIdle <= 1'b0;
    $display("test idle done");
    setup(16'h0006, 16'h0000);
    check("pwm zero", compareOutputPin, 16'h0);
    setup(16'h0006, 16'h0010);
    check("pwm init", compareOutputPin, 16'h1);
    hit(16'h0010, IDLE);
    check("pwm clear", compareOutputPin, 16'h0);
    hit(16'h0000, IDLE);
    check("pwm set", compareOutputPin, 16'h1);
    @(posedge mclk);
    faultInputA <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    check("pwm no fault", compareOutputPin, 16'h1);
    check("pwm no irq", irq, 16'h0);
    @(posedge mclk);
    faultInputA <= 1'b1;
    repeat (4) @(posedge mclk);
    setup(16'h0007, 16'h0010);
    @(posedge mclk);
    faultInputA <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    check("fault pin", compareOutputPin, 16'h0);
    check("fault irq", irq, 16'h1);
    rd(ADDR_CONTROL, 16'h0017, "fault flag");
    rd(ADDR_IRQ, 16'h0302, "fault status");
    wr(ADDR_IRQ, 16'h0000);
    check("irq masked", irq, 16'h0);
    wr(ADDR_IRQ, 16'h0002);
    rd(ADDR_IRQ, 16'h0000, "status cleared");
    wr(ADDR_CONTROL, 16'h0017);
    rd(ADDR_CONTROL, 16'h0007, "flag hw clear");
    @(posedge mclk);
    faultInputA <= 1'b1;
    $display("test fault done");
    wr(ADDR_CONTROL, 16'h0000);
    check("owned off", pinOwned, 16'h0);
    check("off level", compareOutputPin, 16'h0);
    hit(16'h0010, IDLE);
    rd(ADDR_IRQ, 16'h0000, "off no irq");
    $display("test off done");
    conclude();
  end
endmodule // testbench
